/* inc/hpp_oc_if.sv */
// Overcurrent path between the top level and its noise filter.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface hpp_oc_if;
  logic [3:0] raw_n;
  logic       gang;
  logic [3:0] det;
  modport top  (output raw_n, output gang, input det);
  modport filt (input raw_n, input gang, output det);
endinterface

/* inc/hpp_pkg.sv */
// Constants, field layout and timing counts of the hub port power block.
// Assumes a single 10 MHz core clock and an APB register port.
// Operation
// - Power source strap high means bus-powered downstream ports, low self-powered.
// - Memory enable strap high disables the serial memory; its clock pin floats.
// - Memory enable strap low drives a three-state memory clock, weakly pulled low.
// - Memory strap high samples the shared data pin as the gang selector.
// - Memory strap low makes the shared pin the memory data line.
// - Per-port mode gives each of four ports its own active-low overcurrent input.
// - Overcurrent inputs pass a noise filter so spikes are ignored.
// - Four port power outputs are active-low push-pull; low turns power on.
// - Reset low puts all internal logic into its reset state.
// - Suspend output is high in suspend and low in normal operation; the code also drives it high whenever the control suspend bit is set.
// - Clock select low picks 6 MHz crystal, high picks 48 MHz direct clock.
// - From the crystal an internal multiplier makes the 48 and 12 MHz clocks.
// - One upstream and four independent downstream port pairs exist.
// - Ganged ports switch together; any overcurrent turns every port off.
// - Per-port mode makes each power output and overcurrent act on its own port.
// - Clock select high powers down and bypasses multiplier and oscillator.
package hpp_pkg;
  localparam int          NUM_PORTS      = 4;
  // Register byte addresses.
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] STAT_OFS       = 12'h004;
  localparam logic [11:0] SMEM_OFS       = 12'h008;
  // Control fields.
  localparam int          CTRL_PWR_LSB   = 0;
  localparam int          CTRL_SUSP_BIT  = 4;
  localparam logic [4:0]  CTRL_RST       = 5'h00;
  // Status fields; the sticky flag field is write-one-to-clear.
  localparam int          STAT_OCDET_LSB = 0;
  localparam int          STAT_OCFLG_LSB = 4;
  localparam int          STAT_BUSPW_BIT = 8;
  localparam int          STAT_GANG_BIT  = 9;
  localparam int          STAT_XMEM_BIT  = 10;
  localparam int          STAT_DCLK_BIT  = 11;
  localparam int          STAT_PWR_LSB   = 12;
  localparam int          STAT_SUSP_BIT  = 16;
  // Serial memory pin control fields.
  localparam int          SMEM_RUN_BIT   = 0;
  localparam int          SMEM_DOUT_BIT  = 1;
  localparam int          SMEM_DRV_BIT   = 2;
  localparam int          SMEM_DIN_BIT   = 3;
  localparam logic [2:0]  SMEM_RST       = 3'h0;
  // Timing, in ns and in core clock cycles.
  localparam int          CLK_NS         = 100;
  localparam int          OC_FILTER_NS   = 1000;
  localparam int          OC_FILTER_CYC  = (OC_FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SMEM_HALF_NS   = 5000;
  localparam int          SMEM_HALF_CYC  = SMEM_HALF_NS / CLK_NS;
  typedef enum logic {HPP_CAPTURE, HPP_RUN} hpp_state_t;
endpackage

/* rtl/hpp_clk_sel.sv */
// Core clock source control and the serial memory clock divider.
// Assumes the clock select strap is static during operation.
`timescale 1ns/1ps
module hpp_clk_sel
  import hpp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Strap
  input  wire logic clock_source_select,
  // Clock source control
  output logic      multiplier_off,
  output logic      oscillator_off,
  output logic      core_clock_direct,
  // Divided tick
  output logic      smem_tick
);
  localparam logic [7:0] HALF_M1 = 8'(SMEM_HALF_CYC - 1);
  logic [7:0] div_r;
  wire        div_end = (div_r == HALF_M1);
  // ==========================================================
  // Source selection; the multiplier itself is analog.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multiplier_off    <= 1'b0;
      oscillator_off    <= 1'b0;
      core_clock_direct <= 1'b0;
    end else begin
      multiplier_off    <= clock_source_select;
      oscillator_off    <= clock_source_select;
      core_clock_direct <= clock_source_select;
    end
  end
  // ==========================================================
  // Half-period divider for the serial memory clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r     <= 8'h00;
      smem_tick <= 1'b0;
    end else begin
      div_r     <= div_end ? 8'h00 : div_r + 8'h01;
      smem_tick <= div_end;
    end
  end
  a_pll_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    clock_source_select |=> multiplier_off && oscillator_off && core_clock_direct)
    else $error("multiplier not bypassed under direct clock");
endmodule

/* rtl/hpp_oc_filter.sv */
// Per-port overcurrent noise filter with ganged combining.
// Assumes overcurrent inputs are synchronous to the core clock.
`timescale 1ns/1ps
module hpp_oc_filter
  import hpp_pkg::*;
#(
  parameter int FILT_CYC = hpp_pkg::OC_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Overcurrent path
  hpp_oc_if.filt   oc
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CMAX = CW'(FILT_CYC);
  logic [3:0] hit;
  // ==========================================================
  // Filter counters
  genvar i;
  generate
    for (i = 0; i < NUM_PORTS; i++) begin : g_port
      logic [CW-1:0] cnt_r;
      // A high input restarts the count, so any spike is forgotten.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r <= '0;
        end else if (oc.raw_n[i]) begin
          cnt_r <= '0;
        end else if (cnt_r != CMAX) begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
      assign hit[i] = (cnt_r == CMAX);
    end
  endgenerate
  // ==========================================================
  // Output combining
  wire [3:0] det_nxt = oc.gang ? {4{|hit}} : hit;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc.det <= 4'h0;
    end else begin
      oc.det <= det_nxt;
    end
  end
  a_filter_short: assert property (@(posedge clk) disable iff (!rst_n)
    oc.raw_n[0] |=> !hit[0])
    else $error("spike reached the overcurrent filter output");
endmodule

/* rtl/hpp_top.sv */
// Hub port power, straps, overcurrent, suspend and clock source control.
// Assumes an APB master on pclk and straps that stay fixed while running.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module hpp_top
  import hpp_pkg::*;
#(
  parameter int FILT_CYC = hpp_pkg::OC_FILTER_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Straps
  input  wire logic        downstream_power_source_select,
  input  wire logic        external_memory_enable_n,
  input  wire logic        clock_source_select,
  // Serial memory pins
  output logic             serial_memory_clock,
  output logic             serial_memory_clock_oe_n,
  input  wire logic        serial_memory_data_io_in,
  output logic             serial_memory_data_io_out,
  output logic             serial_memory_data_io_oe_n,
  // Downstream port power
  input  wire logic [3:0]  port_overcurrent_n,
  output logic      [3:0]  port_power_enable_n,
  // Suspend
  input  wire logic        hub_suspend,
  output logic             suspend_status,
  // Clock source control
  output logic             analog_clock_multiplier_off,
  output logic             oscillator_off,
  output logic             core_clock_direct
);
  import hpp_pkg::*;

  // ==========================================================
  // Declarations
  hpp_oc_if   oc ();
  hpp_state_t state_r;
  logic       bus_pwr_r;
  logic       gang_r;
  logic       xmem_off_r;
  logic [3:0] ctrl_pwr_r;
  logic       ctrl_susp_r;
  logic [3:0] oc_flag_r;
  logic       smem_run_r;
  logic       smem_dout_r;
  logic       smem_drv_r;
  logic       smem_tick;
  logic       pready_r;
  logic       pslverr_r;
  logic [31:0] prdata_r;

  // ==========================================================
  // Submodules
  assign oc.raw_n = port_overcurrent_n;
  assign oc.gang  = gang_r;

  hpp_oc_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filter (
    .clk   (pclk),
    .rst_n (presetn),
    .oc    (oc)
  );

  hpp_clk_sel u_clk (
    .clk                 (pclk),
    .rst_n               (presetn),
    .clock_source_select (clock_source_select),
    .multiplier_off      (analog_clock_multiplier_off),
    .oscillator_off      (oscillator_off),
    .core_clock_direct   (core_clock_direct),
    .smem_tick           (smem_tick)
  );

  // ==========================================================
  // Strap capture
  // Straps are caught by a clock edge after reset release, never by the
  // asynchronous reset itself; the board keeps them fixed afterwards.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= HPP_CAPTURE;
      bus_pwr_r  <= 1'b0;
      gang_r     <= 1'b0;
      xmem_off_r <= 1'b1;
    end else if (state_r == HPP_CAPTURE) begin
      state_r    <= HPP_RUN;
      bus_pwr_r  <= downstream_power_source_select;
      xmem_off_r <= external_memory_enable_n;
      gang_r     <= external_memory_enable_n & serial_memory_data_io_in;
    end
  end

  // ==========================================================
  // APB decode
  // An unmapped or misaligned address still answers at once, with an error,
  // so a stray access never stalls the master.
  wire setup    = psel & ~penable;
  wire done     = psel & penable & pready_r;
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_stat = (paddr == STAT_OFS);
  wire hit_smem = (paddr == SMEM_OFS);
  wire mapped   = hit_ctrl | hit_stat | hit_smem;
  wire wr_ok    = done & pwrite & ~pslverr_r;
  wire wr_ctrl  = wr_ok & hit_ctrl;
  wire wr_stat  = wr_ok & hit_stat;
  wire wr_smem  = wr_ok & hit_smem;

  wire [3:0] pwr_on = ~port_power_enable_n;

  wire [31:0] rd_ctrl = {27'h0000000, ctrl_susp_r, ctrl_pwr_r};
  wire [31:0] rd_stat = {15'h0000, suspend_status, pwr_on, core_clock_direct,
                         ~xmem_off_r, gang_r, bus_pwr_r, oc_flag_r, oc.det};
  wire [31:0] rd_smem = {28'h0000000, serial_memory_data_io_in, smem_drv_r,
                         smem_dout_r, smem_run_r};
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_stat :
                        hit_smem ? rd_smem : 32'h00000000;

  // Read data is sampled in the setup cycle so that it comes from a flop;
  // the access phase then always finishes in its first cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ==========================================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ctrl_susp_r, ctrl_pwr_r} <= CTRL_RST;
      {smem_drv_r, smem_dout_r, smem_run_r} <= SMEM_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_pwr_r  <= pwdata[CTRL_PWR_LSB +: 4];
        ctrl_susp_r <= pwdata[CTRL_SUSP_BIT];
      end
      if (wr_smem) begin
        smem_run_r  <= pwdata[SMEM_RUN_BIT];
        smem_dout_r <= pwdata[SMEM_DOUT_BIT];
        smem_drv_r  <= pwdata[SMEM_DRV_BIT];
      end
    end
  end

  // ==========================================================
  // Overcurrent flags
  // A new detection wins over a clear in the same cycle.
  // The flag keeps a port off once its switch has cut power and let the
  // fault line go high again; only software can restore the port.
  wire [3:0] flag_clr = wr_stat ? pwdata[STAT_OCFLG_LSB +: 4] : 4'h0;
  wire [3:0] flag_nxt = oc.det | (oc_flag_r & ~flag_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_flag_r <= 4'h0;
    end else begin
      oc_flag_r <= flag_nxt;
    end
  end

  // ==========================================================
  // Port power
  // Ganged mode follows port 0's request and any flag; per-port mode keeps
  // each port on its own request and flag.
  // All ports stay off until the straps are taken, so a ganged board never
  // sees one port switch ahead of the others at start-up.
  wire [3:0] req_eff  = gang_r ? {4{ctrl_pwr_r[0]}} : ctrl_pwr_r;
  wire [3:0] trip     = oc_flag_r | oc.det;
  wire [3:0] trip_eff = gang_r ? {4{|trip}} : trip;
  wire       running  = (state_r == HPP_RUN);
  wire [3:0] on_nxt   = {4{running}} & req_eff & ~trip_eff;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_pwr
      // Each downstream port has its own power flop.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_power_enable_n[p] <= 1'b1;
        end else begin
          port_power_enable_n[p] <= ~on_nxt[p];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Suspend status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_status <= 1'b0;
    end else begin
      suspend_status <= hub_suspend | ctrl_susp_r;
    end
  end

  // ==========================================================
  // Serial memory pins
  // With the interface disabled both pins are released; the clock pin
  // floats and the data pin only carries the gang strap level.
  // The data output is forced low while released, so a stale level is never
  // seen on the pad when the drive enable returns.
  wire smem_en   = running & ~xmem_off_r;
  wire clk_drive = smem_en & smem_run_r;
  wire dat_drive = smem_en & smem_drv_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_memory_clock        <= 1'b0;
      serial_memory_clock_oe_n   <= 1'b1;
      serial_memory_data_io_out  <= 1'b0;
      serial_memory_data_io_oe_n <= 1'b1;
    end else begin
      serial_memory_clock_oe_n   <= ~clk_drive;
      if (!clk_drive) begin
        serial_memory_clock <= 1'b0;
      end else if (smem_tick) begin
        serial_memory_clock <= ~serial_memory_clock;
      end
      serial_memory_data_io_out  <= smem_dout_r & dat_drive;
      serial_memory_data_io_oe_n <= ~dat_drive;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_strap_gang: assert property (
    state_r == HPP_CAPTURE |=> gang_r == ($past(external_memory_enable_n)
                             && $past(serial_memory_data_io_in)))
    else $error("gang selector not taken from the shared pin");
  a_bus_power: assert property (
    state_r == HPP_CAPTURE |=> bus_pwr_r == $past(downstream_power_source_select))
    else $error("power source strap not captured");
  a_clk_float: assert property (
    running && xmem_off_r |=> serial_memory_clock_oe_n && !serial_memory_clock)
    else $error("memory clock driven while interface disabled");
  a_clk_drive: assert property (
    running && !xmem_off_r && smem_run_r |=> !serial_memory_clock_oe_n)
    else $error("memory clock not driven while enabled");
  a_data_release: assert property (
    xmem_off_r |=> serial_memory_data_io_oe_n)
    else $error("data pin driven while used as gang strap");
  a_gang_off: assert property (
    gang_r && (|oc_flag_r) |=> port_power_enable_n == 4'hf)
    else $error("ganged overcurrent left a port powered");
  a_gang_same: assert property (
    gang_r |-> port_power_enable_n == 4'h0 || port_power_enable_n == 4'hf)
    else $error("ganged ports switched apart");
  a_port_trip: assert property (
    !gang_r && oc_flag_r[1] |=> port_power_enable_n[1])
    else $error("tripped port kept power");
  a_port_keep: assert property (
    running && !gang_r && ctrl_pwr_r[2] && !trip[2] ##1 ctrl_pwr_r[2] && !trip[2]
    |-> !port_power_enable_n[2])
    else $error("healthy port lost power");
  a_flag_sets: assert property (
    oc.det[0] |=> oc_flag_r[0]
    ##1 (oc_flag_r[0] || $past(wr_stat && pwdata[STAT_OCFLG_LSB])))
    else $error("overcurrent flag lost");
  a_susp_level: assert property (
    hub_suspend |=> suspend_status ##0 1'b1)
    else $error("suspend status low during suspend");
  a_susp_clear: assert property (
    !hub_suspend && !ctrl_susp_r |=> !suspend_status)
    else $error("suspend status high in normal operation");
  a_apb_answer: assert property (
    setup |=> pready && (pslverr == !$past(mapped)))
    else $error("APB answer not given in the access cycle");
  a_reset_off: assert property (
    state_r == HPP_CAPTURE |=> port_power_enable_n == 4'hf)
    else $error("port powered before straps were taken");

  // ==========================================================
  // Checks on the bus, the flags, port power, suspend and the serial pins
  a_apb_idle: assert property (
    !setup |=> !pready)
    else $error("APB ready without a setup cycle");
  a_rd_data: assert property (
    setup |=> prdata == $past(rd_mux))
    else $error("read data not taken in the setup cycle");
  a_rd_hold: assert property (
    !setup |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");
  a_err_write: assert property (
    done && pwrite && pslverr
    |=> $stable({ctrl_susp_r, ctrl_pwr_r, smem_drv_r, smem_dout_r, smem_run_r}))
    else $error("refused write changed a register");
  a_ctrl_write: assert property (
    wr_ctrl |=> ctrl_pwr_r == $past(pwdata[CTRL_PWR_LSB +: 4]))
    else $error("power request not written");
  a_flag_set: assert property (
    oc.det[2] |=> oc_flag_r[2])
    else $error("detection lost against a clear");
  a_flag_clear: assert property (
    wr_stat && pwdata[STAT_OCFLG_LSB + 1] && !oc.det[1] |=> !oc_flag_r[1])
    else $error("sticky flag not cleared by a write of one");
  a_det_trip: assert property (
    running && !gang_r && oc.det[3] |=> port_power_enable_n[3])
    else $error("detected port kept power");
  a_gang_trip: assert property (
    gang_r && (|oc.det) |=> port_power_enable_n == 4'hf)
    else $error("ganged detection left a port powered");
  a_req_off: assert property (
    running && !gang_r && !ctrl_pwr_r[0] |=> port_power_enable_n[0])
    else $error("unrequested port powered");
  a_dat_drive: assert property (
    running && !xmem_off_r && smem_drv_r |=> !serial_memory_data_io_oe_n
    && serial_memory_data_io_out == $past(smem_dout_r))
    else $error("memory data pin not driven with its value");
  a_clk_toggle: assert property (
    clk_drive && smem_tick |=> serial_memory_clock != $past(serial_memory_clock))
    else $error("memory clock missed its tick");
  a_clk_still: assert property (
    clk_drive && !smem_tick |=> $stable(serial_memory_clock))
    else $error("memory clock moved between ticks");
  a_susp_force: assert property (
    ctrl_susp_r |=> suspend_status)
    else $error("forced suspend not shown");
endmodule

/* sim/hpp_switch_model.sv */
// Board model: the four external power switches and the shared data/gang pin.
// Assumes the bench drives the fault inputs and the strap levels from pclk.
`timescale 1ns/1ps
module hpp_switch_model (
  // Switch side
  input  wire logic [3:0] power_enable_n,
  input  wire logic [3:0] fault,
  output logic      [3:0] overcurrent_n,
  // Shared data/gang pin
  input  wire logic       gang_level,
  input  wire logic       memory_enable_n,
  input  wire logic       data_out,
  input  wire logic       data_oe_n,
  output logic            data_in
);
  // ==========================================================================
  // Overcurrent reporting
  // A switch only reports a fault while it is actually sourcing power.
  wire logic [3:0] trip_n = ~(fault & ~power_enable_n);
  // Ganged boards tie all four flags together, so any trip pulls every line.
  assign overcurrent_n = gang_level ? {4{&trip_n}} : trip_n;
  // ==========================================================================
  // Shared pin level
  // The gang strap is a fixed board level; an idle memory pin sits at its pulldown.
  assign data_in = !data_oe_n ? data_out : (memory_enable_n ? gang_level : 1'b0);
endmodule

/* sim/test_hub_port_power_config.sv */
// Self-checking bench for the hub port power block over its APB port.
// Assumes the board model above and a short overcurrent filter count.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module test_hub_port_power_config;
  import hpp_pkg::*;
  localparam int FILT = 2;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus_pw = 1'b1;
  logic        xmem_n = 1'b1;
  logic        csel = 1'b0;
  logic        gang = 1'b0;
  logic        hub_susp = 1'b0;
  logic [3:0]  fault = 4'h0;
  logic [3:0]  oc_n;
  logic [3:0]  pwr_n;
  logic        sm_clk, sm_clk_oe_n, d_in, d_out, d_oe_n, susp, mult_off, osc_off, direct;
  logic [31:0] rd;
  logic        err;
  logic        prev;
  int          mismatches = 0;
  int          checked = 0;
  int          n;
  always #50 pclk = ~pclk;
  hpp_top #(.FILT_CYC(FILT)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .downstream_power_source_select(bus_pw), .external_memory_enable_n(xmem_n),
    .clock_source_select(csel), .serial_memory_clock(sm_clk),
    .serial_memory_clock_oe_n(sm_clk_oe_n), .serial_memory_data_io_in(d_in),
    .serial_memory_data_io_out(d_out), .serial_memory_data_io_oe_n(d_oe_n),
    .port_overcurrent_n(oc_n), .port_power_enable_n(pwr_n), .hub_suspend(hub_susp),
    .suspend_status(susp), .analog_clock_multiplier_off(mult_off),
    .oscillator_off(osc_off), .core_clock_direct(direct));
  hpp_switch_model u_board (
    .power_enable_n(pwr_n), .fault(fault), .overcurrent_n(oc_n), .gang_level(gang),
    .memory_enable_n(xmem_n), .data_out(d_out), .data_oe_n(d_oe_n), .data_in(d_in));
  // ==========================================================================
  // Bus and reset tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic do_reset(input logic bp, input logic g, input logic xm, input logic cs);
    @(posedge pclk);
    presetn <= 1'b0; bus_pw <= bp; gang <= g; xmem_n <= xm; csel <= cs; fault <= 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog, sized well above the few hundred cycles the tests need.
  initial begin
    #(100 * 20000);
    mismatches++;
    wrap_up();
  end
  // ==========================================================================
  // Tests
  initial begin
    // Per-port, bus-powered, crystal clock, no external memory.
    do_reset(1'b1, 1'b0, 1'b1, 1'b0);
    `CHK("pwr_rst", 4'hf, pwr_n)
    `CHK("susp_rst", 1'b0, susp)
    `CHK("clk_ctl", 3'h0, {mult_off, osc_off, direct})
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK("stat_rst", 32'h00000100, rd)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1'b1, 12'h00d, 32'h0000001f);
    `CHK("unmapped_wr", 1'b1, err)
    apb(1'b1, SMEM_OFS, 32'h7);
    repeat (60) @(posedge pclk);
    `CHK("mem_off", 2'h3, {sm_clk_oe_n, d_oe_n})
    $display("test straps done");
    apb(1'b1, CTRL_OFS, 32'h0000000f);
    repeat (3) @(posedge pclk);
    `CHK("pwr_on", 4'h0, pwr_n)
    fault <= 4'h2;
    @(posedge pclk);
    fault <= 4'h0;
    repeat (6) @(posedge pclk);
    `CHK("spike", 4'h0, pwr_n)
    fault <= 4'h2;
    repeat (10) @(posedge pclk);
    `CHK("oc_one", 4'h2, pwr_n)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK("oc_flag", 32'h0000d120, rd)
    fault <= 4'h0;
    apb(1'b1, STAT_OFS, 32'h00000020);
    repeat (4) @(posedge pclk);
    `CHK("oc_clear", 4'h0, pwr_n)
    $display("test per-port done");
    apb(1'b1, CTRL_OFS, 32'h0000001f);
    repeat (2) @(posedge pclk);
    `CHK("susp_sw", 1'b1, susp)
    apb(1'b1, CTRL_OFS, 32'h0000000f);
    hub_susp <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("susp_hub", 1'b1, susp)
    hub_susp <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("susp_off", 1'b0, susp)
    $display("test suspend done");
    // Ganged, self-powered, direct clock.
    do_reset(1'b0, 1'b1, 1'b1, 1'b1);
    `CHK("clk_dir", 3'h7, {mult_off, osc_off, direct})
    apb(1'b1, CTRL_OFS, 32'h00000001);
    repeat (3) @(posedge pclk);
    `CHK("gang_on", 4'h0, pwr_n)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK("gang_stat", 32'h0000fa00, rd & 32'hffffff00)
    fault <= 4'h8;
    repeat (10) @(posedge pclk);
    `CHK("gang_trip", 4'hf, pwr_n)
    $display("test ganged done");
    // Serial memory enabled.
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    apb(1'b1, SMEM_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("sclk_oe", 1'b0, sm_clk_oe_n)
    prev = sm_clk;
    n = 0;
    while (n < 60 && sm_clk === prev) begin
      @(posedge pclk);
      n++;
    end
    prev = sm_clk;
    n = 0;
    while (n < 60 && sm_clk === prev) begin
      @(posedge pclk);
      n++;
    end
    `CHK("sclk_half", SMEM_HALF_CYC, n)
    apb(1'b1, SMEM_OFS, 32'h6);
    repeat (2) @(posedge pclk);
    `CHK("sdat_drv", 3'h3, {d_oe_n, d_out, sm_clk_oe_n})
    apb(1'b0, SMEM_OFS, 32'h0);
    `CHK("sdat_rd", 32'h0000000e, rd)
    $display("test serial memory done");
    wrap_up();
  end
endmodule
